/* File: src/fieu_top.sv */
// filtered input edge event unit: filters, edge events, ticker, diagnostics
`include "fieu_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module fieu_top #(
  parameter int unsigned CHANNELS = 4,
  parameter int unsigned CYC_2731US = (`FIEU_T_2731US * `FIEU_US_NS) / `FIEU_CLK_PERIOD_NS
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [CHANNELS-1:0] input_channel_i,
  input wire fieu_pkg::fieu_rec_req_t rec_req_i,
  output logic [7:0] rec_rdata_o,
  output logic rec_rvalid_o,
  output logic proc_irq_o,
  input wire logic proc_ack_i,
  output fieu_pkg::fieu_proc_rec_t proc_rec_o,
  output logic diag_incoming_o,
  output logic diag_going_o,
  input wire logic diag_ack_i,
  output logic fault_indicator_o
);

  localparam int unsigned FW = 15;
  localparam logic [FW-1:0] CYC_2US = FW'((`FIEU_T_2US * `FIEU_US_NS) / `FIEU_CLK_PERIOD_NS);
  localparam logic [FW-1:0] CYC_4US = FW'((`FIEU_T_4US * `FIEU_US_NS) / `FIEU_CLK_PERIOD_NS);
  localparam logic [FW-1:0] CYC_12US = FW'((`FIEU_T_12US * `FIEU_US_NS) / `FIEU_CLK_PERIOD_NS);
  localparam logic [FW-1:0] CYC_86US = FW'((`FIEU_T_86US * `FIEU_US_NS) / `FIEU_CLK_PERIOD_NS);
  localparam logic [FW-1:0] CYC_342US = FW'((`FIEU_T_342US * `FIEU_US_NS) / `FIEU_CLK_PERIOD_NS);
  localparam logic [FW-1:0] CYC_LONG = FW'(CYC_2731US);
  localparam logic [3:0] US_LAST = 4'(`FIEU_US_CYC - 1);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (CHANNELS != 4) begin : g_bad_channels
    $error("channel count must be 4");
  end
  if (CYC_2731US < 1 || CYC_2731US >= (1 << FW)) begin : g_bad_long
    $error("long filter count out of range");
  end

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  // filter code to cycle count
  function automatic logic [FW-1:0] fieu_delay_cyc(input logic [7:0] code);
    logic [FW-1:0] cyc;
    cyc = CYC_4US;
    case (code)
      `FIEU_FD_2US: cyc = CYC_2US;
      `FIEU_FD_4US: cyc = CYC_4US;
      `FIEU_FD_12US: cyc = CYC_12US;
      `FIEU_FD_86US: cyc = CYC_86US;
      `FIEU_FD_342US: cyc = CYC_342US;
      `FIEU_FD_2731US: cyc = CYC_LONG;
      default: cyc = CYC_4US;
    endcase
    return cyc;
  endfunction

  // filter code legality
  function automatic logic fieu_code_ok(input logic [7:0] code);
    return code == `FIEU_FD_2US || code == `FIEU_FD_4US || code == `FIEU_FD_12US ||
           code == `FIEU_FD_86US || code == `FIEU_FD_342US || code == `FIEU_FD_2731US;
  endfunction

  // ----------------------------------------------------------------
  // parameter records
  // ----------------------------------------------------------------
  logic [7:0] diag_irq_enable;
  logic [7:0] filter_delay_select [CHANNELS];
  logic [3:0] rise_edge_mask;
  logic [3:0] fall_edge_mask;
  logic wr_diag_irq_enable;
  logic wr_filter;
  logic wr_masks;
  assign wr_diag_irq_enable = rec_req_i.wr && rec_req_i.record_set_number == `FIEU_RS_DIAG_IRQ_ENABLE;
  assign wr_filter = rec_req_i.wr && rec_req_i.record_set_number == `FIEU_RS_FILTER;
  assign wr_masks = rec_req_i.wr && rec_req_i.record_set_number == `FIEU_RS_MASKS;

  // diagnostic enable byte, only the two codes are taken
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      diag_irq_enable <= `FIEU_DIAG_OFF;
    end else if (ce_i && wr_diag_irq_enable && rec_req_i.index == 5'd0 &&
                 (rec_req_i.wdata == `FIEU_DIAG_OFF || rec_req_i.wdata == `FIEU_DIAG_ON)) begin
      diag_irq_enable <= rec_req_i.wdata;
    end
  end

  // edge masks, reserved bits dropped
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rise_edge_mask <= 4'h0;
      fall_edge_mask <= 4'h0;
    end else if (ce_i && wr_masks) begin
      if (rec_req_i.index == 5'd0) begin
        rise_edge_mask <= rec_req_i.wdata[3:0];
      end
      if (rec_req_i.index == 5'd1) begin
        fall_edge_mask <= rec_req_i.wdata[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // input sync and filters
  // ----------------------------------------------------------------
  logic [CHANNELS-1:0] sync_a;
  logic [CHANNELS-1:0] sync_b;
  logic [CHANNELS-1:0] filtered;
  logic [CHANNELS-1:0] filtered_d;
  logic [CHANNELS-1:0] rise_evt;
  logic [CHANNELS-1:0] fall_evt;
  logic [CHANNELS-1:0] chan_evt;

  // two-stage synchroniser for the pins
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync_a <= '0;
      sync_b <= '0;
    end else if (ce_i) begin
      sync_a <= input_channel_i;
      sync_b <= sync_a;
    end
  end

  for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
    logic [FW-1:0] stable_cnt;

    // per-channel delay code, illegal codes ignored
    always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
        filter_delay_select[c] <= `FIEU_FD_RESET;
      end else if (ce_i && wr_filter && rec_req_i.index == 5'(c) && fieu_code_ok(rec_req_i.wdata)) begin
        filter_delay_select[c] <= rec_req_i.wdata;
      end
    end

    // new level must hold for the whole delay before it passes
    always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
        stable_cnt <= '0;
        filtered[c] <= 1'b0;
      end else if (ce_i) begin
        if (sync_b[c] == filtered[c]) begin
          stable_cnt <= '0;
        end else if (stable_cnt + FW'(1) >= fieu_delay_cyc(filter_delay_select[c])) begin
          stable_cnt <= '0;
          filtered[c] <= sync_b[c];
        end else begin
          stable_cnt <= stable_cnt + FW'(1);
        end
      end
    end
  end

  // previous filtered level for edge detection
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      filtered_d <= '0;
    end else if (ce_i) begin
      filtered_d <= filtered;
    end
  end

  assign rise_evt = filtered & ~filtered_d & rise_edge_mask;
  assign fall_evt = ~filtered & filtered_d & fall_edge_mask;
  assign chan_evt = rise_evt | fall_evt;

  // ----------------------------------------------------------------
  // microsecond ticker
  // ----------------------------------------------------------------
  logic [3:0] us_div;
  logic [31:0] us_ticker;

  // free-running, wraps naturally at the top
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      us_div <= 4'h0;
      us_ticker <= 32'h0000_0000;
    end else if (ce_i) begin
      if (us_div == US_LAST) begin
        us_div <= 4'h0;
        us_ticker <= us_ticker + 32'h0000_0001;
      end else begin
        us_div <= us_div + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // process interrupt
  // ----------------------------------------------------------------
  logic accept_evt;
  logic lost_evt;
  logic proc_busy;
  assign proc_busy = proc_irq_o && !proc_ack_i;
  // events inside the diagnostic window are dropped
  assign accept_evt = |chan_evt && !fault_indicator_o && !proc_busy;
  assign lost_evt = |chan_evt && !fault_indicator_o && proc_busy;

  // capture record and hold the request until acknowledged
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      proc_irq_o <= 1'b0;
      proc_rec_o <= '0;
    end else if (ce_i) begin
      if (accept_evt) begin
        proc_irq_o <= 1'b1;
        proc_rec_o.edge_event_flags <= {4'h0, chan_evt};
        proc_rec_o.captured_input_state <= {4'h0, filtered};
        proc_rec_o.event_timestamp_low <= us_ticker[15:0];
      end else if (proc_ack_i) begin
        proc_irq_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // diagnostic flags and state
  // ----------------------------------------------------------------
  logic [3:0] edge_lost_flags;
  logic plost_flag;
  logic overflow_flag;
  logic diag_cause;
  logic [31:0] diag_timestamp;
  fieu_pkg::fieu_diag_state_t diag_state;
  assign diag_cause = plost_flag || overflow_flag;

  // lost-edge and internal flags; a new set wins over the clear
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      edge_lost_flags <= 4'h0;
      plost_flag <= 1'b0;
      overflow_flag <= 1'b0;
    end else if (ce_i) begin
      edge_lost_flags <= (diag_ack_i ? 4'h0 : edge_lost_flags) | (lost_evt ? chan_evt : 4'h0);
      plost_flag <= (plost_flag && !diag_ack_i) || lost_evt;
      overflow_flag <= (overflow_flag && !diag_ack_i) || (lost_evt && plost_flag);
    end
  end

  // ticker copy when the cause first appears
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      diag_timestamp <= 32'h0000_0000;
    end else if (ce_i && lost_evt && !plost_flag) begin
      diag_timestamp <= us_ticker;
    end
  end

  // incoming when enabled cause appears, going once it disappears
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      diag_state <= fieu_pkg::FIEU_DIAG_IDLE;
      diag_incoming_o <= 1'b0;
      diag_going_o <= 1'b0;
      fault_indicator_o <= 1'b0;
    end else if (ce_i) begin
      diag_incoming_o <= 1'b0;
      diag_going_o <= 1'b0;
      case (diag_state)
        fieu_pkg::FIEU_DIAG_IDLE: begin
          if (diag_cause && diag_irq_enable == `FIEU_DIAG_ON) begin
            diag_state <= fieu_pkg::FIEU_DIAG_ACTIVE;
            diag_incoming_o <= 1'b1;
            fault_indicator_o <= 1'b1;
          end
        end
        fieu_pkg::FIEU_DIAG_ACTIVE: begin
          if (!diag_cause) begin
            diag_state <= fieu_pkg::FIEU_DIAG_IDLE;
            diag_going_o <= 1'b1;
            fault_indicator_o <= 1'b0;
          end
        end
        default: diag_state <= fieu_pkg::FIEU_DIAG_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // record reads
  // ----------------------------------------------------------------
  logic [7:0] diag_byte;
  logic [7:0] err_summary;
  logic [7:0] internal_fault_flags;
  assign internal_fault_flags = {1'b0, plost_flag, 2'b00, overflow_flag, 3'b000};
  assign err_summary = {4'h0, |edge_lost_flags, 1'b0, 1'b0, diag_cause};

  // diagnostic record byte selector
  always_comb begin
    diag_byte = 8'h00;
    case (rec_req_i.index)
      `FIEU_DB_ERR: diag_byte = err_summary;
      `FIEU_DB_CLASS: diag_byte = `FIEU_MODULE_CLASS;
      `FIEU_DB_INTERNAL: diag_byte = internal_fault_flags;
      `FIEU_DB_KIND: diag_byte = `FIEU_CHANNEL_KIND;
      `FIEU_DB_BITS: diag_byte = `FIEU_DIAG_BITS;
      `FIEU_DB_COUNT: diag_byte = `FIEU_CHANNELS;
      `FIEU_DB_LOST: diag_byte = {4'h0, edge_lost_flags};
      `FIEU_DB_TS: diag_byte = diag_timestamp[31:24];
      `FIEU_DB_TS + 5'd1: diag_byte = diag_timestamp[23:16];
      `FIEU_DB_TS + 5'd2: diag_byte = diag_timestamp[15:8];
      `FIEU_DB_TS + 5'd3: diag_byte = diag_timestamp[7:0];
      default: diag_byte = 8'h00;
    endcase
  end

  // answer one cycle after the read strobe
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rec_rdata_o <= 8'h00;
      rec_rvalid_o <= 1'b0;
    end else if (ce_i) begin
      rec_rvalid_o <= rec_req_i.rd;
      rec_rdata_o <= 8'h00;
      if (rec_req_i.rd) begin
        if (rec_req_i.record_set_number == `FIEU_RS_DIAG_FULL && rec_req_i.index < `FIEU_DIAG_LEN) begin
          rec_rdata_o <= diag_byte;
        end else if (rec_req_i.record_set_number == `FIEU_RS_DIAG_SHORT &&
                     rec_req_i.index < `FIEU_DIAG_SHORT_LEN) begin
          rec_rdata_o <= diag_byte;
        end else if (rec_req_i.record_set_number == `FIEU_RS_MASKS) begin
          rec_rdata_o <= rec_req_i.index == 5'd0 ? {4'h0, rise_edge_mask} :
                         rec_req_i.index == 5'd1 ? {4'h0, fall_edge_mask} : 8'h00;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  property p_diag_irq_enable_codes;
    diag_irq_enable == `FIEU_DIAG_OFF || diag_irq_enable == `FIEU_DIAG_ON;
  endproperty
  a_diag_irq_enable_codes: assert property (p_diag_irq_enable_codes) else $error("diag enable holds illegal code");

  property p_filter_codes;
    fieu_code_ok(filter_delay_select[0]) && fieu_code_ok(filter_delay_select[1]) &&
    fieu_code_ok(filter_delay_select[2]) && fieu_code_ok(filter_delay_select[3]);
  endproperty
  a_filter_codes: assert property (p_filter_codes) else $error("filter code illegal");

  property p_filter_hold;
    ce_i && filtered != filtered_d |-> $past(sync_b) == filtered;
  endproperty
  a_filter_hold: assert property (p_filter_hold) else $error("filter passed unstable level");

  property p_proc_raise;
    ce_i && accept_evt |=> proc_irq_o && proc_rec_o.edge_event_flags == {4'h0, $past(chan_evt)};
  endproperty
  a_proc_raise: assert property (p_proc_raise) else $error("edge did not raise process record");

  property p_proc_state;
    ce_i && accept_evt |=> proc_rec_o.captured_input_state == {4'h0, $past(filtered)} &&
      proc_rec_o.event_timestamp_low == $past(us_ticker[15:0]);
  endproperty
  a_proc_state: assert property (p_proc_state) else $error("process record capture wrong");

  property p_ticker;
    ce_i && us_div == US_LAST |=> us_ticker == $past(us_ticker) + 32'h0000_0001;
  endproperty
  a_ticker: assert property (p_ticker) else $error("ticker did not advance");

  property p_incoming_enabled;
    diag_incoming_o |-> diag_irq_enable == `FIEU_DIAG_ON && fault_indicator_o;
  endproperty
  a_incoming_enabled: assert property (p_incoming_enabled) else $error("incoming without enable");

  property p_going_auto;
    ce_i && fault_indicator_o && !diag_cause |=> diag_going_o && !fault_indicator_o;
  endproperty
  a_going_auto: assert property (p_going_auto) else $error("going diagnostic missing");

  property p_discard;
    fault_indicator_o |-> !accept_evt;
  endproperty
  a_discard: assert property (p_discard) else $error("event accepted in diagnostic window");

  property p_lost_flags;
    ce_i && lost_evt |=> plost_flag && (edge_lost_flags & $past(chan_evt)) == $past(chan_evt);
  endproperty
  a_lost_flags: assert property (p_lost_flags) else $error("lost edge not flagged");

  property p_reserved_zero;
    proc_rec_o.edge_event_flags[7:4] == 4'h0 && proc_rec_o.captured_input_state[7:4] == 4'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

  c_proc: cover property (ce_i && accept_evt ##1 proc_irq_o);
  c_lost: cover property (ce_i && lost_evt);
  c_diag_cycle: cover property (diag_incoming_o ##[1:200] diag_going_o);
  c_diag_read: cover property (rec_req_i.rd && rec_req_i.record_set_number == `FIEU_RS_DIAG_FULL);

endmodule // fieu_top

`default_nettype wire

/* File: src/fieu_defs.svh */
// constants for the filtered input edge event unit
`ifndef FIEU_DEFS_SVH
`define FIEU_DEFS_SVH

// clock and time base
`define FIEU_CLK_PERIOD_NS 100
`define FIEU_US_NS 1000
`define FIEU_US_CYC ((`FIEU_US_NS) / (`FIEU_CLK_PERIOD_NS))

// diagnostic interrupt enable codes
`define FIEU_DIAG_OFF 8'h00
`define FIEU_DIAG_ON 8'h40

// filter delay codes and their times in microseconds
`define FIEU_FD_2US 8'h00
`define FIEU_FD_4US 8'h02
`define FIEU_FD_12US 8'h04
`define FIEU_FD_86US 8'h07
`define FIEU_FD_342US 8'h09
`define FIEU_FD_2731US 8'h0c
`define FIEU_FD_RESET 8'h02
`define FIEU_T_2US 2
`define FIEU_T_4US 4
`define FIEU_T_12US 12
`define FIEU_T_86US 86
`define FIEU_T_342US 342
`define FIEU_T_2731US 2731

// record set numbers
`define FIEU_RS_DIAG_IRQ_ENABLE 8'h00
`define FIEU_RS_FILTER 8'h01
`define FIEU_RS_MASKS 8'h80
`define FIEU_RS_DIAG_FULL 8'h01
`define FIEU_RS_DIAG_SHORT 8'h00
`define FIEU_DIAG_SHORT_LEN 5'd4
`define FIEU_DIAG_LEN 5'd20

// diagnostic record byte positions
`define FIEU_DB_ERR 5'd0
`define FIEU_DB_CLASS 5'd1
`define FIEU_DB_INTERNAL 5'd3
`define FIEU_DB_KIND 5'd4
`define FIEU_DB_BITS 5'd5
`define FIEU_DB_COUNT 5'd6
`define FIEU_DB_LOST 5'd7
`define FIEU_DB_TS 5'd16

// diagnostic constants and bit positions
`define FIEU_MODULE_CLASS 8'h1f
`define FIEU_CHANNEL_KIND 8'h70
`define FIEU_DIAG_BITS 8'h00
`define FIEU_CHANNELS 8'h04
`define FIEU_ERR_MODULE_BIT 0
`define FIEU_ERR_EXTERNAL_BIT 2
`define FIEU_ERR_CHANNEL_BIT 3
`define FIEU_INT_OVERFLOW_BIT 3
`define FIEU_INT_PLOST_BIT 6

`endif

/* File: src/fieu_pkg.sv */
// types shared by the filtered input edge event unit
package fieu_pkg;

  // process interrupt record
  typedef struct packed {
    logic [7:0] edge_event_flags;
    logic [7:0] captured_input_state;
    logic [15:0] event_timestamp_low;
  } fieu_proc_rec_t;

  // record port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] record_set_number;
    logic [4:0] index;
    logic [7:0] wdata;
  } fieu_rec_req_t;

  // diagnostic interrupt state
  typedef enum logic [0:0] {
    FIEU_DIAG_IDLE,
    FIEU_DIAG_ACTIVE
  } fieu_diag_state_t;

endpackage

/* File: testbench/fieu_ctrl_model.sv */
// controller model that acknowledges process interrupts
`timescale 1ns/1ps
`default_nettype none
module fieu_ctrl_model (
  input wire logic clk_i,
  input wire logic auto_ack_i,
  input wire logic [3:0] ack_dly_i,
  input wire logic proc_irq_i,
  output logic proc_ack_o,
  output int acks_o
);
  // ack a pending interrupt after a settable delay, held off when auto ack is low
  initial begin
    proc_ack_o = 1'b0;
    acks_o = 0;
    forever begin
      @(negedge clk_i);
      if (proc_irq_i === 1'b1 && auto_ack_i) begin
        repeat (ack_dly_i) @(negedge clk_i);
        proc_ack_o = 1'b1;
        @(negedge clk_i);
        proc_ack_o = 1'b0;
        acks_o++;
      end
    end
  end
endmodule // fieu_ctrl_model
`default_nettype wire

/* File: testbench/fieu_top_tb_top.sv */
// self-checking bench for the filtered input edge event unit
`timescale 1ns/1ps
`default_nettype none
module fieu_top_tb_top;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [3:0] pin = 4'h0;
  fieu_pkg::fieu_rec_req_t req = '0;
  logic dack = 1'b0;
  logic aack = 1'b1;
  logic [7:0] rdata;
  logic rvalid, pirq, pack, din, dgo, fault;
  fieu_pkg::fieu_proc_rec_t prec;
  int acks, cyc = 0, n_in = 0, n_go = 0, n;
  int errors = 0;
  int num_checks = 0;
  logic [7:0] d;
  logic [31:0] dts;
  logic [7:0] dref [9] = '{8'h00, 8'h1f, 8'h00, 8'h00, 8'h70, 8'h00, 8'h04, 8'h00, 8'h00};
  logic [7:0] fc [7] = '{8'h00, 8'h03, 8'h02, 8'h04, 8'h07, 8'h09, 8'h0c};
  int fw [7] = '{20, 20, 40, 120, 860, 3420, 300};

  always #50 clk_i = ~clk_i;

  // count cycles since reset and diagnostic pulses
  always @(posedge clk_i) begin
    if (!reset_i) cyc++;
    if (din === 1'b1) n_in++;
    if (dgo === 1'b1) n_go++;
  end

  fieu_top #(.CYC_2731US(300)) i_dut (.clk_i(clk_i), .reset_i(reset_i), .ce_i(1'b1),
    .input_channel_i(pin), .rec_req_i(req), .rec_rdata_o(rdata), .rec_rvalid_o(rvalid),
    .proc_irq_o(pirq), .proc_ack_i(pack), .proc_rec_o(prec), .diag_incoming_o(din),
    .diag_going_o(dgo), .diag_ack_i(dack), .fault_indicator_o(fault));

  fieu_ctrl_model i_ctrl (.clk_i(clk_i), .auto_ack_i(aack), .ack_dly_i(4'h4),
    .proc_irq_i(pirq), .proc_ack_o(pack), .acks_o(acks));

  // ----------------------
  // tasks
  // ----------------------
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task chk_rng(input string nm, input int lo, input int hi, input logic [31:0] g);
    num_checks++;
    if ($isunknown(g) || int'(g) < lo || int'(g) > hi) begin
      errors++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  task wr(input logic [7:0] s, input logic [4:0] i, input logic [7:0] v);
    @(negedge clk_i);
    req = '{wr: 1'b1, rd: 1'b0, record_set_number: s, index: i, wdata: v};
    @(negedge clk_i);
    req.wr = 1'b0;
  endtask

  task rd(input logic [7:0] s, input logic [4:0] i);
    @(negedge clk_i);
    req = '{wr: 1'b0, rd: 1'b1, record_set_number: s, index: i, wdata: 8'h00};
    @(negedge clk_i);
    // answer stands for the one cycle after the read edge
    chk("read valid", 32'h1, {31'h0, rvalid});
    d = rdata;
    req.rd = 1'b0;
    @(negedge clk_i);
    chk("read valid drop", 32'h0, {31'h0, rvalid});
  endtask

  task rchk(input logic [7:0] s, input logic [4:0] i, input logic [7:0] e);
    rd(s, i);
    chk($sformatf("set %h byte %0d", s, i), {24'h0, e}, {24'h0, d});
  endtask

  task wait_irq(input int mx);
    n = 0;
    while (pirq !== 1'b1 && n < mx) begin
      @(negedge clk_i);
      n++;
    end
  endtask

  task pins(input logic v, input int w);
    pin[0] = v;
    repeat (w) @(negedge clk_i);
  endtask

  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // watchdog well beyond the expected run of some 10300 cycles
  initial begin
    repeat (40000) @(posedge clk_i);
    errors++;
    tally_and_finish;
  end

  // ----------------------
  // tests
  // ----------------------
  initial begin
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 1'b0;
    for (int k = 0; k < 9; k++) rchk(8'h01, k[4:0], dref[k]);
    for (int k = 0; k < 4; k++) rchk(8'h00, k[4:0], dref[k]);
    rchk(8'h80, 5'd0, 8'h00);
    rchk(8'h80, 5'd1, 8'h00);
    wr(8'h80, 5'd0, 8'hff);
    wr(8'h80, 5'd1, 8'hf5);
    rchk(8'h80, 5'd0, 8'h0f);
    rchk(8'h80, 5'd1, 8'h05);
    wr(8'h80, 5'd1, 8'h00);
    wr(8'h80, 5'd0, 8'h01);
    $display("test registers done");
    for (int k = 0; k < 7; k++) begin
      wr(8'h01, 5'd0, fc[k]);
      pin[0] = 1'b1;
      wait_irq(fw[k] + 20);
      chk_rng("filter delay", fw[k] + 2, fw[k] + 6, n);
      chk("edge flags", 32'h1, prec.edge_event_flags);
      chk("input state", 32'h1, prec.captured_input_state);
      chk_rng("timestamp", cyc / 10 - 2, cyc / 10 + 1, prec.event_timestamp_low);
      pins(1'b0, fw[k] + 20);
      chk("masked fall", 32'h0, pirq);
    end
    $display("test filters done");
    wr(8'h80, 5'd0, 8'h00);
    wr(8'h80, 5'd1, 8'h02);
    pin[2] = 1'b1;
    pin[1] = 1'b1;
    repeat (60) @(negedge clk_i);
    chk("masked rise", 32'h0, pirq);
    pin[1] = 1'b0;
    wait_irq(60);
    chk("fall flags", 32'h2, prec.edge_event_flags);
    chk("fall state", 32'h4, prec.captured_input_state);
    repeat (20) @(negedge clk_i);
    $display("test falling edge done");
    wr(8'h00, 5'd0, 8'h40);
    wr(8'h80, 5'd1, 8'h01);
    wr(8'h80, 5'd0, 8'h01);
    wr(8'h01, 5'd0, 8'h00);
    aack = 1'b0;
    pins(1'b1, 40);
    pins(1'b0, 40);
    chk("incoming count", 32'h1, n_in);
    chk("fault on", 32'h1, fault);
    rchk(8'h01, 5'd0, 8'h09);
    rchk(8'h01, 5'd3, 8'h40);
    rchk(8'h01, 5'd7, 8'h01);
    for (int k = 16; k < 20; k++) begin
      rd(8'h01, k[4:0]);
      dts = {dts[23:0], d};
    end
    chk_rng("diag ticker", cyc / 10 - 25, cyc / 10, dts);
    pins(1'b1, 40);
    rchk(8'h01, 5'd3, 8'h40);
    aack = 1'b1;
    repeat (20) @(negedge clk_i);
    pins(1'b0, 40);
    chk("discarded edge", 32'h0, pirq);
    dack = 1'b1;
    @(negedge clk_i);
    dack = 1'b0;
    repeat (3) @(negedge clk_i);
    chk("going count", 32'h1, n_go);
    chk("fault off", 32'h0, fault);
    rchk(8'h01, 5'd3, 8'h00);
    $display("test diagnostic enabled done");
    wr(8'h00, 5'd0, 8'h00);
    aack = 1'b0;
    pins(1'b1, 40);
    pins(1'b0, 40);
    pins(1'b1, 40);
    chk("no incoming", 32'h1, n_in);
    chk("fault stays off", 32'h0, fault);
    rchk(8'h01, 5'd3, 8'h48);
    rchk(8'h00, 5'd3, 8'h48);
    aack = 1'b1;
    $display("test diagnostic disabled done");
    tally_and_finish;
  end
endmodule // fieu_top_tb_top
`default_nettype wire
